// ===== hw/asr_ctrl.sv
// Purpose: host controller driving an asynchronous 512k x 8 sram
// Assumes: pins registered here; read data passes two flops
// Notes:   one access at a time; retention entered on request
`include "asr_regs.svh"

// Operation
// - host keeps write strobe high for the whole read cycle
// - host drives no write data while device outputs may still drive
// - host keeps chip select low at least 60 ns before write ends
// - host deselects chip at least 0 ns before retention begins
module asr_ctrl #(
  parameter int AW = `ASR_ADDR_W,
  parameter int DW = `ASR_DATA_W,
  parameter int TW = `ASR_TMR_W,
  parameter int REC_CYCLES = `ASR_REC_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready_q,
  // user response
  output logic resp_valid_q,
  output logic [DW-1:0] resp_rdata_q,
  // retention control
  input wire logic ret_req,
  output logic ret_ack_q,
  // memory pins
  output logic [AW-1:0] word_address_q,
  output logic cs_n_q,
  output logic oe_n_q,
  output logic we_n_q,
  input wire logic [DW-1:0] data_lines_i,
  output logic [DW-1:0] data_lines_o_q,
  output logic data_lines_oe_n_q
);

  asr_pkg::asr_state_t state_q, state_d;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic take;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] dq_sync1_q, dq_sync2_q;

  // ========================================================
  // decode helpers
  // host drives the data lines through the whole write
  function automatic logic wr_phase(input asr_pkg::asr_state_t s);
    return (s == asr_pkg::ASR_WR_SETUP) || (s == asr_pkg::ASR_WR_PULSE) ||
           (s == asr_pkg::ASR_WR_END);
  endfunction : wr_phase

  // chip select low in read and in write up to its end
  function automatic logic sel_phase(input asr_pkg::asr_state_t s);
    return (s == asr_pkg::ASR_RD) || (s == asr_pkg::ASR_WR_SETUP) ||
           (s == asr_pkg::ASR_WR_PULSE);
  endfunction : sel_phase

  // ========================================================
  // phase timer
  asr_timer #(
    .W(TW)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // ========================================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    take = 1'b0;
    case (state_q)
      asr_pkg::ASR_IDLE: begin
        if (req_valid && req_ready_q) begin
          take = 1'b1;
          tmr_load = 1'b1;
          if (req_write) begin
            state_d = asr_pkg::ASR_WR_SETUP;
            tmr_val = TW'(`ASR_SETUP_CYC - 1);
          end else begin
            // access wait
            // strobes held through access time plus synchroniser
            state_d = asr_pkg::ASR_RD;
            tmr_val = TW'(`ASR_RD_CYC - 1);
          end
        end else if (ret_req) begin
          // deselect first
          // select is already high here; ack follows a cycle later
          state_d = asr_pkg::ASR_RETAIN;
        end
      end
      asr_pkg::ASR_RD: begin
        if (tmr_done) begin
          // float before drive
          // wait out the device's float time before any write
          state_d = asr_pkg::ASR_TURN;
          tmr_load = 1'b1;
          tmr_val = TW'(`ASR_HZ_CYC - 1);
        end
      end
      asr_pkg::ASR_TURN: begin
        if (tmr_done) begin
          state_d = asr_pkg::ASR_IDLE;
        end
      end
      asr_pkg::ASR_WR_SETUP: begin
        if (tmr_done) begin
          // select width
          // pulse covers both strobe width and select-to-end
          state_d = asr_pkg::ASR_WR_PULSE;
          tmr_load = 1'b1;
          tmr_val = TW'(`ASR_WP_CYC - 1);
        end
      end
      asr_pkg::ASR_WR_PULSE: begin
        if (tmr_done) begin
          state_d = asr_pkg::ASR_WR_END;
          tmr_load = 1'b1;
          tmr_val = TW'(`ASR_END_CYC - 1);
        end
      end
      asr_pkg::ASR_WR_END: begin
        if (tmr_done) begin
          state_d = asr_pkg::ASR_IDLE;
        end
      end
      asr_pkg::ASR_RETAIN: begin
        if (!ret_req) begin
          // supply recovery before the next access
          state_d = asr_pkg::ASR_RECOVER;
          tmr_load = 1'b1;
          tmr_val = TW'(REC_CYCLES - 1);
        end
      end
      asr_pkg::ASR_RECOVER: begin
        if (tmr_done) begin
          state_d = asr_pkg::ASR_IDLE;
        end
      end
      default: begin
        state_d = asr_pkg::ASR_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= asr_pkg::ASR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ========================================================
  // request capture; address stays put until the next request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      word_address_q <= '0;
      wdata_q <= '0;
    end else if (take) begin
      word_address_q <= req_addr;
      wdata_q <= req_wdata;
    end
  end

  // ========================================================
  // control strobes, registered from the next state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else begin
      cs_n_q <= !sel_phase(state_d);
      // strobe off in read
      // gate low only in a read, strobe low only in a write pulse
      oe_n_q <= (state_d != asr_pkg::ASR_RD);
      we_n_q <= (state_d != asr_pkg::ASR_WR_PULSE);
    end
  end

  // ========================================================
  // data drive; gate is high in writes so there is no fight
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_lines_o_q <= '0;
      data_lines_oe_n_q <= 1'b1;
    end else begin
      data_lines_oe_n_q <= !wr_phase(state_d);
      // take the byte straight from the request on the taking edge so
      // the lines never carry the previous write's byte
      data_lines_o_q <= wr_phase(state_d) ?
        (take ? req_wdata : wdata_q) : '0;
    end
  end

  // ========================================================
  // read data synchroniser; pins are not on our clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dq_sync1_q <= '0;
      dq_sync2_q <= '0;
    end else begin
      dq_sync1_q <= data_lines_i;
      dq_sync2_q <= dq_sync1_q;
    end
  end

  // ========================================================
  // user handshake and response
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_ready_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= '0;
      ret_ack_q <= 1'b0;
    end else begin
      req_ready_q <= (state_d == asr_pkg::ASR_IDLE);
      resp_valid_q <= (state_q == asr_pkg::ASR_RD) && tmr_done;
      if ((state_q == asr_pkg::ASR_RD) && tmr_done) begin
        resp_rdata_q <= dq_sync2_q;
      end
      ret_ack_q <= (state_q == asr_pkg::ASR_RETAIN) && ret_req;
    end
  end

  // ========================================================
  // checks
  localparam int CW_CYC = `ASR_CYC_CEIL(`ASR_T_CW_NS);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_read_we_high: assert property (
    (!cs_n_q && !oe_n_q) |-> we_n_q)
    else $error("write strobe low during read");

  chk_drive_no_fight: assert property (
    !data_lines_oe_n_q |-> oe_n_q && $past(oe_n_q))
    else $error("host drives while device may drive");

  chk_select_before_end: assert property (
    ($rose(we_n_q) && $rose(cs_n_q)) |->
      !$past(cs_n_q, 1) && !$past(cs_n_q, 2) && !$past(cs_n_q, 3))
    else $error("select too short before write end");

  chk_pulse_width: assert property (
    $fell(we_n_q) |-> (!we_n_q && !cs_n_q)[*3] ##1 we_n_q)
    else $error("write pulse length wrong");

  chk_retain_deselect: assert property (
    ret_ack_q |-> cs_n_q && $past(cs_n_q))
    else $error("retention with chip selected");

  chk_read_capture: assert property (
    $fell(oe_n_q) |-> (!oe_n_q)[*5] ##1 (oe_n_q && resp_valid_q))
    else $error("read response out of step");

  chk_cw_figure: assert property (
    $fell(cs_n_q) && we_n_q |-> ##[1:2] (!we_n_q && CW_CYC == 3) or
      !oe_n_q)
    else $error("select fell without access");

  cov_read: cover property (resp_valid_q);
  cov_write: cover property ($rose(we_n_q) ##1 req_ready_q);
  cov_retain: cover property (ret_ack_q ##[1:8] !ret_ack_q);
  cov_back_to_back: cover property (resp_valid_q ##[1:4] !we_n_q);

endmodule : asr_ctrl

// ===== hw/asr_pkg.sv
// Purpose: shared types of the sram host
// Assumes: nothing
// Notes:   state codes left to the tool
package asr_pkg;

  // ========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ASR_IDLE,
    ASR_RD,
    ASR_TURN,
    ASR_WR_SETUP,
    ASR_WR_PULSE,
    ASR_WR_END,
    ASR_RETAIN,
    ASR_RECOVER
  } asr_state_t;

endpackage : asr_pkg

// ===== hw/asr_regs.svh
// Purpose: timing figures and derived cycle counts for the sram host
// Assumes: core_clk at 40 MHz
// Notes:   least times round up to whole cycles
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

// ==========================================================
// clock and bus widths
`define ASR_CLK_NS 25
`define ASR_ADDR_W 19
`define ASR_DATA_W 8
`define ASR_TMR_W 18
`define ASR_SYNC_STAGES 2

// ==========================================================
// device timing in its own unit
`define ASR_T_ACC_NS 70
`define ASR_T_OE_NS 35
`define ASR_T_HZ_NS 25
`define ASR_T_WP_NS 50
`define ASR_T_CW_NS 60
`define ASR_T_CDR_NS 0
`define ASR_T_REC_MS 5

// ==========================================================
// derived cycle counts
`define ASR_CYC_CEIL(ns) (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define ASR_ACC_CYC `ASR_MAX(`ASR_CYC_CEIL(`ASR_T_ACC_NS), \
  `ASR_CYC_CEIL(`ASR_T_OE_NS))
`define ASR_RD_CYC (`ASR_ACC_CYC + `ASR_SYNC_STAGES)
`define ASR_HZ_CYC `ASR_MAX(`ASR_CYC_CEIL(`ASR_T_HZ_NS), 1)
`define ASR_WP_CYC `ASR_MAX(`ASR_CYC_CEIL(`ASR_T_WP_NS), \
  `ASR_CYC_CEIL(`ASR_T_CW_NS))
`define ASR_SETUP_CYC 1
`define ASR_END_CYC 1
`define ASR_CDR_CYC `ASR_MAX(`ASR_CYC_CEIL(`ASR_T_CDR_NS), 1)
`define ASR_REC_CYC `ASR_CYC_CEIL(`ASR_T_REC_MS * 1000000)

`endif

// ===== hw/asr_timer.sv
// Purpose: loadable down counter timing each phase of a cycle
// Assumes: load value is phase length minus one
// Notes:   done is high while the count stands at zero
module asr_timer #(
  parameter int W = 18
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic done
);

  logic [W-1:0] cnt_q;

  // ========================================================
  // counter
  // count stops at zero so a stale phase never wraps round
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);

endmodule : asr_timer

// ===== verification/asr_sram_model.sv
// Purpose: behavioural 512k x 8 static memory on the host's pins
// Assumes: reads evaluated combinationally after a fixed delay
// Notes:   unwritten bytes read as unknown
module asr_sram_model #(
  parameter int DLY_NS = 10
) (
  // memory pins
  input wire logic [18:0] word_address,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] data_bus,
  // device drive
  output logic [7:0] dev_data,
  output logic dev_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========================================================
  // storage
  // byte wide array
  logic [7:0] mem [0:524287];
  logic wr_open = 1'b0;
  logic [18:0] wr_addr;
  logic [7:0] wr_byte;
  assign #(DLY_NS) dev_oe_n = !(!cs_n && !oe_n && we_n);
  assign #(DLY_NS) dev_data = mem[word_address];
  // latch while both low, store when the first one rises
  always @(cs_n or we_n or data_bus or word_address) begin
    if (!cs_n && !we_n) begin
      wr_open = 1'b1;
      wr_addr = word_address;
      wr_byte = data_bus;
    end else if (wr_open) begin
      mem[wr_addr] = wr_byte;
      wr_open = 1'b0;
    end
  end
endmodule : asr_sram_model

// ===== verification/test_async_sram_512k_by_8.sv
// Purpose: self-checking bench of the sram host controller
// Assumes: recovery shortened to 8 cycles
// Notes:   released data lines toggle so stale bytes never pass
`include "asr_regs.svh"
module test_async_sram_512k_by_8;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REC = 8;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, ret_req = 1'b0;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0] req_wdata = 8'h00, float_pat = 8'h55;
  logic req_ready_q, resp_valid_q, ret_ack_q, cs_n_q, oe_n_q, we_n_q;
  logic data_lines_oe_n_q, dev_oe_n;
  logic [7:0] resp_rdata_q, data_lines_o_q, dev_data, data_bus;
  logic [18:0] word_address_q;
  logic [18:0] tadr [3] = '{19'h00000, 19'h7ffff, 19'h2a55a};
  logic [7:0] tdat [3] = '{8'ha5, 8'h5a, 8'h3c};
  int failures = 0, samples_checked = 0, cyc = 0;
  // ========================================================
  // clock, wire resolution, instances
  always #12.5 core_clk = ~core_clk;
  // no pull on the lines, so an idle bus changes every cycle
  always @(posedge core_clk) float_pat <= ~float_pat;
  assign data_bus = !data_lines_oe_n_q ? data_lines_o_q :
    (!dev_oe_n ? dev_data : float_pat);
  asr_ctrl #(.REC_CYCLES(REC)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready_q(req_ready_q), .resp_valid_q(resp_valid_q),
    .resp_rdata_q(resp_rdata_q), .ret_req(ret_req),
    .ret_ack_q(ret_ack_q), .word_address_q(word_address_q),
    .cs_n_q(cs_n_q), .oe_n_q(oe_n_q), .we_n_q(we_n_q),
    .data_lines_i(data_bus), .data_lines_o_q(data_lines_o_q),
    .data_lines_oe_n_q(data_lines_oe_n_q));
  asr_sram_model mdl (.word_address(word_address_q), .cs_n(cs_n_q),
    .oe_n(oe_n_q), .we_n(we_n_q), .data_bus(data_bus),
    .dev_data(dev_data), .dev_oe_n(dev_oe_n));
  // ========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  // host may drive only once the device has floated
  always @(negedge core_clk) begin
    if (!sys_rst && data_lines_oe_n_q === 1'b0) begin
      chk(dev_oe_n, 1'b1);
    end
  end
  // ========================================================
  // one access; counts are negedges after the taking edge
  task automatic access(input logic w, input logic [18:0] a,
    input logic [7:0] d, output logic [7:0] rd, output int rsp,
    output int rdy, output int csl, output int wel);
    int i;
    rsp = 0;
    rdy = 0;
    csl = 0;
    wel = 0;
    rd = 8'h00;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(negedge core_clk);
    i = 0;
    while (req_ready_q !== 1'b1 && i < 50) begin
      @(negedge core_clk);
      i++;
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (i = 1; i <= 12 && rdy == 0; i++) begin
      @(negedge core_clk);
      if (i == 1) chk(word_address_q, a);
      if (resp_valid_q === 1'b1) begin
        rsp = (rsp == 0) ? i : 99;
        rd = resp_rdata_q;
      end
      if (req_ready_q === 1'b1) rdy = i;
      if (cs_n_q === 1'b0) csl++;
      if (we_n_q === 1'b0) wel++;
    end
  endtask : access
  // ========================================================
  // scenarios
  task automatic t_rw;
    logic [7:0] rd;
    int rsp, rdy, csl, wel;
    for (int k = 0; k < 3; k++) begin
      access(1'b1, tadr[k], tdat[k], rd, rsp, rdy, csl, wel);
      chk(rdy, 6);
      chk(wel, 3);
      chk(csl, 4);
      chk(rsp, 0);
      chk(mdl.mem[tadr[k]], tdat[k]);
    end
    for (int k = 0; k < 3; k++) begin
      access(1'b0, tadr[k], 8'h00, rd, rsp, rdy, csl, wel);
      chk(rd, tdat[k]);
      chk(rsp, 6);
      chk(rdy, 7);
      chk(wel, 0);
      chk(csl, 5);
    end
  endtask : t_rw
  // second write to one place must win
  task automatic t_overwrite;
    logic [7:0] rd;
    int rsp, rdy, csl, wel;
    access(1'b1, 19'h12345, 8'hc3, rd, rsp, rdy, csl, wel);
    access(1'b1, 19'h12345, 8'hff, rd, rsp, rdy, csl, wel);
    access(1'b0, 19'h12345, 8'h00, rd, rsp, rdy, csl, wel);
    chk(rd, 8'hff);
  endtask : t_overwrite
  task automatic t_retain;
    logic [7:0] rd;
    int i, rsp, rdy, csl, wel;
    @(posedge core_clk);
    ret_req <= 1'b1;
    i = 0;
    while (ret_ack_q !== 1'b1 && i < 10) begin
      @(negedge core_clk);
      chk(cs_n_q, 1'b1);
      i++;
    end
    chk(i <= 4, 1'b1);
    repeat (3) @(negedge core_clk);
    chk({ret_ack_q, req_ready_q, cs_n_q}, 3'b101);
    @(posedge core_clk);
    ret_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(ret_ack_q, 1'b0);
    i = 0;
    while (req_ready_q !== 1'b1 && i < REC + 20) begin
      @(negedge core_clk);
      i++;
    end
    chk(i >= REC - 2 && i <= REC + 2, 1'b1);
    access(1'b0, tadr[0], 8'h00, rd, rsp, rdy, csl, wel);
    chk(rd, tdat[0]);
  endtask : t_retain
  // ========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    chk({cs_n_q, oe_n_q, we_n_q, data_lines_oe_n_q, req_ready_q},
      5'b11110);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    t_rw();
    t_overwrite();
    t_retain();
    finish_test();
  end
endmodule : test_async_sram_512k_by_8
